// ### rtl/dsk_exec.sv
// Execution unit for decrement_skip_if_zero and decrement_skip_if_nonzero
`timescale 1ns/100ps
module dsk_exec (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Instruction issue
   input  wire logic        start,
   input  wire logic        skipOnNonzero,
   input  wire logic [7:0]  fileAddr,
   input  wire logic        destSel,
   input  wire logic        accessSel,
   input  wire logic        nextTwoWord,
   output logic             ready,
   // Core context
   input  wire logic        extEnable,
   input  wire logic [3:0]  bankSelect,
   input  wire logic [11:0] indexBase,
   // Data memory
   output logic      [11:0] memAddr,
   input  wire logic [7:0]  memRdData,
   output logic             fileWrEn,
   output logic      [7:0]  wrData,
   // Working accumulator
   output logic             accumWrEn,
   // Sequencing results
   output logic             discardNext,
   output logic             done,
   output logic      [1:0]  cycleCount,
   output logic             indexedUsed
);

   ////////////////////////////////////////////////////////////////////////////
   // State and next values

   dsk_pkg::dsk_state_t state;
   dsk_pkg::dsk_state_t next_state;
   logic             opNonzero;
   logic             next_opNonzero;
   logic             opDest;
   logic             next_opDest;
   logic             opTwoWord;
   logic             next_opTwoWord;
   logic      [11:0] next_memAddr;
   logic             next_fileWrEn;
   logic             next_accumWrEn;
   logic      [7:0]  next_wrData;
   logic             next_discardNext;
   logic             next_done;
   logic      [1:0]  next_cycleCount;
   logic             next_indexedUsed;
   logic      [11:0] formedAddr;
   logic             formedIndexed;
   logic      [7:0]  decResult;
   logic             skipNow;

   ////////////////////////////////////////////////////////////////////////////
   // Address forming

   dsk_addr_gen u_addr (
      .fileAddr    (fileAddr),
      .accessSel   (accessSel),
      .extEnable   (extEnable),
      .bankSelect  (bankSelect),
      .indexBase   (indexBase),
      .operandAddr (formedAddr),
      .indexedMode (formedIndexed)
   );

   // Issue is accepted only while idle
   assign ready = (state == dsk_pkg::ST_IDLE);

   // Eight-bit wrapping decrement and skip decision
   assign decResult = 8'(memRdData - dsk_pkg::DEC_STEP);
   assign skipNow   = opNonzero ? (decResult != dsk_pkg::ZERO_BYTE)
                                : (decResult == dsk_pkg::ZERO_BYTE);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state and output computation

   always_comb begin
      next_state       = state;
      next_opNonzero   = opNonzero;
      next_opDest      = opDest;
      next_opTwoWord   = opTwoWord;
      next_memAddr     = memAddr;
      next_fileWrEn    = 1'b0;
      next_accumWrEn   = 1'b0;
      next_wrData      = wrData;
      next_discardNext = 1'b0;
      next_done        = 1'b0;
      next_cycleCount  = cycleCount;
      next_indexedUsed = indexedUsed;
      case (state)
         dsk_pkg::ST_IDLE: begin
            if (start) begin
               next_opNonzero   = skipOnNonzero;
               next_opDest      = destSel;
               next_opTwoWord   = nextTwoWord;
               next_memAddr     = formedAddr;
               next_indexedUsed = formedIndexed;
               next_state       = dsk_pkg::ST_EXEC;
            end
         end
         dsk_pkg::ST_EXEC: begin
            // Result goes to accumulator or back to the file byte
            next_wrData    = decResult;
            next_accumWrEn = (opDest == dsk_pkg::DEST_ACCUM);
            next_fileWrEn  = (opDest == dsk_pkg::DEST_FILE);
            if (skipNow) begin
               next_discardNext = 1'b1;
               next_state       = dsk_pkg::ST_NOP1;
            end else begin
               next_done       = 1'b1;
               next_cycleCount = dsk_pkg::CYC_PLAIN;
               next_state      = dsk_pkg::ST_IDLE;
            end
         end
         dsk_pkg::ST_NOP1: begin
            // First no-operation slot replaces the fetched word
            if (opTwoWord) begin
               next_discardNext = 1'b1;
               next_state       = dsk_pkg::ST_NOP2;
            end else begin
               next_done       = 1'b1;
               next_cycleCount = dsk_pkg::CYC_SKIP1;
               next_state      = dsk_pkg::ST_IDLE;
            end
         end
         dsk_pkg::ST_NOP2: begin
            // Second word of a skipped two-word instruction
            next_done       = 1'b1;
            next_cycleCount = dsk_pkg::CYC_SKIP2;
            next_state      = dsk_pkg::ST_IDLE;
         end
         default: begin
            next_state = dsk_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state       <= dsk_pkg::ST_IDLE;
         opNonzero   <= 1'b0;
         opDest      <= dsk_pkg::DEST_FILE;
         opTwoWord   <= 1'b0;
         memAddr     <= 12'h000;
         fileWrEn    <= 1'b0;
         accumWrEn   <= 1'b0;
         wrData      <= 8'h00;
         discardNext <= 1'b0;
         done        <= 1'b0;
         cycleCount  <= 2'h0;
         indexedUsed <= 1'b0;
      end else begin
         state       <= next_state;
         opNonzero   <= next_opNonzero;
         opDest      <= next_opDest;
         opTwoWord   <= next_opTwoWord;
         memAddr     <= next_memAddr;
         fileWrEn    <= next_fileWrEn;
         accumWrEn   <= next_accumWrEn;
         wrData      <= next_wrData;
         discardNext <= next_discardNext;
         done        <= next_done;
         cycleCount  <= next_cycleCount;
         indexedUsed <= next_indexedUsed;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence s_exec_skip;
      state == dsk_pkg::ST_EXEC && skipNow;
   endsequence

   sequence s_two_nops;
      discardNext ##1 discardNext ##1 (done && cycleCount == dsk_pkg::CYC_SKIP2);
   endsequence

   property p_accum_dest;
      @(posedge clk) disable iff (!resetn)
      state == dsk_pkg::ST_EXEC && opDest == dsk_pkg::DEST_ACCUM
      |=> accumWrEn && !fileWrEn && wrData == 8'($past(memRdData) - dsk_pkg::DEC_STEP);
   endproperty
   a_accum_dest: assert property (p_accum_dest) else $error("accumulator write wrong");

   property p_file_dest;
      @(posedge clk) disable iff (!resetn)
      state == dsk_pkg::ST_EXEC && opDest == dsk_pkg::DEST_FILE
      |=> fileWrEn && !accumWrEn && memAddr == $past(memAddr)
          && wrData == 8'($past(memRdData) - dsk_pkg::DEC_STEP);
   endproperty
   a_file_dest: assert property (p_file_dest) else $error("file write-back wrong");

   property p_skip_zero;
      @(posedge clk) disable iff (!resetn)
      state == dsk_pkg::ST_EXEC && !opNonzero
      |=> discardNext == ($past(memRdData) == dsk_pkg::DEC_STEP);
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("zero skip decision wrong");

   property p_skip_nonzero;
      @(posedge clk) disable iff (!resetn)
      state == dsk_pkg::ST_EXEC && opNonzero
      |=> discardNext == ($past(memRdData) != dsk_pkg::DEC_STEP);
   endproperty
   a_skip_nonzero: assert property (p_skip_nonzero) else $error("nonzero skip decision wrong");

   property p_one_nop;
      @(posedge clk) disable iff (!resetn)
      s_exec_skip and !opTwoWord
      |=> discardNext ##1 (done && cycleCount == dsk_pkg::CYC_SKIP1 && !discardNext);
   endproperty
   a_one_nop: assert property (p_one_nop) else $error("single skip not two cycles");

   property p_two_nops;
      @(posedge clk) disable iff (!resetn)
      s_exec_skip and opTwoWord |=> s_two_nops;
   endproperty
   a_two_nops: assert property (p_two_nops) else $error("two-word skip not three cycles");

   property p_fixed_bank;
      @(posedge clk) disable iff (!resetn)
      ready && start && !accessSel && !(extEnable && fileAddr <= dsk_pkg::IDX_LIMIT)
      |=> memAddr == {($past(fileAddr) < dsk_pkg::ACC_SPLIT) ? dsk_pkg::ACC_LOW_BANK : dsk_pkg::ACC_HIGH_BANK,
                      $past(fileAddr)} && !indexedUsed;
   endproperty
   a_fixed_bank: assert property (p_fixed_bank) else $error("access bank address wrong");

   property p_banked;
      @(posedge clk) disable iff (!resetn)
      ready && start && accessSel
      |=> memAddr == {$past(bankSelect), $past(fileAddr)} && !indexedUsed;
   endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong");

   property p_indexed;
      @(posedge clk) disable iff (!resetn)
      ready && start && !accessSel && extEnable && fileAddr <= dsk_pkg::IDX_LIMIT
      |=> indexedUsed && memAddr == 12'($past(indexBase) + {4'h0, $past(fileAddr)});
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");

   property p_wrap;
      @(posedge clk) disable iff (!resetn)
      state == dsk_pkg::ST_EXEC && memRdData == dsk_pkg::ZERO_BYTE |=> wrData == ~dsk_pkg::ZERO_BYTE;
   endproperty
   a_wrap: assert property (p_wrap) else $error("decrement does not wrap");

endmodule

// ### shared/dsk_pkg.sv
// Shared constants and types for the decrement-and-skip execution unit
package dsk_pkg;

   localparam int          DATA_W          = 8;
   localparam int          ADDR_W          = 12;
   localparam int          BANK_W          = 4;

   // Destination and access select encodings
   localparam logic        DEST_ACCUM      = 1'h0;
   localparam logic        DEST_FILE       = 1'h1;
   localparam logic        ACC_FIXED       = 1'h0;
   localparam logic        ACC_BANKED      = 1'h1;

   // Address map of the fixed access bank
   localparam logic [7:0]  IDX_LIMIT       = 8'h5f;
   localparam logic [7:0]  ACC_SPLIT       = 8'h60;
   localparam logic [3:0]  ACC_HIGH_BANK   = 4'hf;
   localparam logic [3:0]  ACC_LOW_BANK    = 4'h0;

   // Arithmetic constants
   localparam logic [7:0]  DEC_STEP        = 8'h01;
   localparam logic [7:0]  ZERO_BYTE       = 8'h00;
   localparam logic [7:0]  ZERO_ADDR8      = 8'h00;

   // Instruction cycle totals
   localparam logic [1:0]  CYC_PLAIN       = 2'h1;
   localparam logic [1:0]  CYC_SKIP1       = 2'h2;
   localparam logic [1:0]  CYC_SKIP2       = 2'h3;

   // Execution states, Gray coded along idle, execute, nop, second nop
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1,
      ST_NOP1 = 2'h3,
      ST_NOP2 = 2'h2
   } dsk_state_t;

endpackage

// ### rtl/dsk_addr_gen.sv
// Operand address former for fixed, banked and indexed addressing
`timescale 1ns/100ps
module dsk_addr_gen (
   // Instruction fields
   input  wire logic [7:0]  fileAddr,
   input  wire logic        accessSel,
   // Core context
   input  wire logic        extEnable,
   input  wire logic [3:0]  bankSelect,
   input  wire logic [11:0] indexBase,
   // Formed address
   output logic      [11:0] operandAddr,
   output logic             indexedMode
);

   // Pick the addressing form of the operand
   always_comb begin
      indexedMode = (accessSel == dsk_pkg::ACC_FIXED) && extEnable
                    && (fileAddr <= dsk_pkg::IDX_LIMIT);
      if (indexedMode) begin
         operandAddr = 12'(indexBase + {4'h0, fileAddr});
      end else if (accessSel == dsk_pkg::ACC_BANKED) begin
         operandAddr = {bankSelect, fileAddr};
      end else if (fileAddr < dsk_pkg::ACC_SPLIT) begin
         operandAddr = {dsk_pkg::ACC_LOW_BANK, fileAddr};
      end else begin
         operandAddr = {dsk_pkg::ACC_HIGH_BANK, fileAddr};
      end
   end

endmodule

// ### verif/dsk_exec_tb.sv
// Self-checking testbench for the decrement-and-skip execution unit
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end
module dsk_exec_tb;
   logic        clk, resetn, start, skipOnNonzero, destSel, accessSel, nextTwoWord, extEnable;
   logic [7:0]  fileAddr, memRdData, wrData;
   logic [3:0]  bankSelect;
   logic [11:0] indexBase, memAddr;
   logic        ready, fileWrEn, accumWrEn, discardNext, done, indexedUsed;
   logic [1:0]  cycleCount;
   int          n_errors = 0;
   int          n_checks = 0;

   ////////////////////////////////////////////////////////////////////////
   // Device under test
   dsk_exec dut_u (
      .clk(clk), .resetn(resetn), .start(start), .skipOnNonzero(skipOnNonzero),
      .fileAddr(fileAddr), .destSel(destSel), .accessSel(accessSel), .nextTwoWord(nextTwoWord),
      .ready(ready), .extEnable(extEnable), .bankSelect(bankSelect), .indexBase(indexBase),
      .memAddr(memAddr), .memRdData(memRdData), .fileWrEn(fileWrEn), .wrData(wrData),
      .accumWrEn(accumWrEn), .discardNext(discardNext), .done(done), .cycleCount(cycleCount),
      .indexedUsed(indexedUsed)
   );

   // Free-running 100 MHz clock
   initial clk = 1'b0;
   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Counts, verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One instruction from issue to its last cycle; returns in the done cycle so the next can follow at once
   task automatic op(input logic nz, input logic [7:0] f, input logic d, input logic a, input logic tw,
                     input logic ext, input logic [3:0] bk, input logic [11:0] base, input logic [7:0] rd);
      logic [7:0]  res;
      logic        skip;
      logic        idx;
      logic [11:0] ea;
      int          n;
      res  = rd - 8'h01;
      skip = nz ? (res != 8'h00) : (res == 8'h00);
      idx  = ext && !a && (f <= 8'h5f);
      ea   = a ? {bk, f} : (idx ? base + {4'h0, f} : (f < 8'h60 ? {4'h0, f} : {4'hf, f}));
      n    = 0;
      while (ready !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 20) begin
         n_errors++;
         end_sim();
      end
      start = 1'b1; skipOnNonzero = nz; fileAddr = f; destSel = d; accessSel = a;
      nextTwoWord = tw; extEnable = ext; bankSelect = bk; indexBase = base;
      @(posedge clk);
      #1;
      // Fields change after issue; only the sampled copies may count
      start = 1'b0; fileAddr = ~f; bankSelect = ~bk; indexBase = ~base; destSel = ~d; memRdData = rd;
      `CHK("memAddr", ea, memAddr)
      `CHK("ready", 1'b0, ready)
      @(posedge clk);
      #1;
      memRdData = ~rd;
      `CHK("wrData", res, wrData)
      `CHK("accumWrEn", ~d, accumWrEn)
      `CHK("fileWrEn", d, fileWrEn)
      `CHK("discardNext", skip, discardNext)
      `CHK("done", ~skip, done)
      if (skip) begin
         @(posedge clk);
         #1;
         `CHK("write once", 1'b0, fileWrEn | accumWrEn)
         `CHK("discardNext2", tw, discardNext)
         `CHK("done2", ~tw, done)
         if (tw) begin
            @(posedge clk);
            #1;
            `CHK("discardNext3", 1'b0, discardNext)
            `CHK("done3", 1'b1, done)
         end
      end
      `CHK("cycleCount", skip ? (tw ? 2'h3 : 2'h2) : 2'h1, cycleCount)
      `CHK("indexedUsed", idx, indexedUsed)
      `CHK("ready", 1'b1, ready)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_dest();
      op(1'b0, 8'h10, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 12'h000, 8'h05);
      op(1'b0, 8'h7a, 1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 12'h000, 8'h81);
      $display("test destination done");
   endtask

   task automatic t_skip_zero();
      op(1'b0, 8'h22, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2, 12'h000, 8'h01);
      op(1'b0, 8'h23, 1'b0, 1'b1, 1'b1, 1'b0, 4'h2, 12'h000, 8'h01);
      op(1'b0, 8'h24, 1'b0, 1'b1, 1'b1, 1'b0, 4'h2, 12'h000, 8'h02);
      $display("test skip on zero done");
   endtask

   task automatic t_skip_nonzero();
      op(1'b1, 8'h30, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 12'h000, 8'h00);
      op(1'b1, 8'h31, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 12'h000, 8'h01);
      op(1'b1, 8'hff, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 12'h000, 8'hff);
      $display("test skip on nonzero done");
   endtask

   task automatic t_banked();
      op(1'b0, 8'h20, 1'b1, 1'b1, 1'b0, 1'b0, 4'h7, 12'h000, 8'h09);
      op(1'b0, 8'h05, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 12'h123, 8'h09);
      $display("test banked done");
   endtask

   task automatic t_indexed();
      op(1'b0, 8'h5f, 1'b1, 1'b0, 1'b0, 1'b1, 4'h5, 12'hff0, 8'h44);
      op(1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 4'h5, 12'h200, 8'h44);
      op(1'b0, 8'h60, 1'b1, 1'b0, 1'b0, 1'b1, 4'h5, 12'h200, 8'h44);
      op(1'b0, 8'h5f, 1'b1, 1'b0, 1'b0, 1'b0, 4'h5, 12'h200, 8'h44);
      $display("test indexed done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      resetn = 1'b0; start = 1'b0; skipOnNonzero = 1'b0; fileAddr = 8'h00; destSel = 1'b1;
      accessSel = 1'b0; nextTwoWord = 1'b0; extEnable = 1'b0; bankSelect = 4'h0;
      indexBase = 12'h000; memRdData = 8'h00;
      repeat (2) @(posedge clk);
      #1;
      `CHK("reset ready", 1'b1, ready)
      `CHK("reset outputs", 1'b0, done | fileWrEn | accumWrEn | discardNext | indexedUsed)
      `CHK("reset memAddr", 12'h000, memAddr)
      `CHK("reset cycleCount", 2'h0, cycleCount)
      resetn = 1'b1;
      t_dest();
      t_skip_zero();
      t_skip_nonzero();
      t_banked();
      t_indexed();
      end_sim();
   end
endmodule
